// File: src/busbar_channel_handling.sv
// bus bar handling: sinks, compare scans, protector and balance masking
`timescale 1ns/10ps
`default_nettype none
module busbar_channel_handling #(
    parameter int unsigned n = busbar_pkg::num_channels,
    parameter int unsigned w = busbar_pkg::value_width
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // configuration
    input wire logic [1:0] open_wire_sink_select_i,
    input wire logic [7:0] busbar_channel_position_low_i,
    input wire logic [7:0] busbar_channel_position_high_i,
    input wire logic [3:0] shared_channel_locator_i,
    input wire logic shared_locator_valid_i,
    input wire logic [w-1:0] compare_tolerance_i,
    input wire logic compare_go_i,
    // converter results (same clock)
    input wire logic [n*w-1:0] main_cell_values_i,
    input wire logic [n*w-1:0] aux_cell_values_i,
    input wire logic [w-1:0] main_busbar_value_i,
    input wire logic [w-1:0] aux_busbar_value_i,
    // protector and balancing raw events
    input wire logic [n-1:0] over_voltage_raw_i,
    input wire logic [n-1:0] under_voltage_raw_i,
    input wire logic protector_enable_i,
    input wire logic [n-1:0] balance_enable_i,
    input wire logic [n-1:0] balance_timer_expired_i,
    input wire logic [n-1:0] balance_voltage_reached_i,
    // outputs
    output logic busbar_positive_input_sink_o,
    output logic busbar_negative_input_sink_o,
    output logic [n*w-1:0] cell_result_pair_o,
    output logic [n-1:0] over_voltage_o,
    output logic [n-1:0] under_voltage_o,
    output logic [n-1:0] balance_switch_o,
    output logic balancing_complete_flag_o,
    output logic [n-1:0] compare_fault_o,
    output logic busbar_compare_fault_o,
    output logic compare_done_o,
    output logic [3:0] correction_channel_o,
    output logic correction_valid_o
);
    busbar_value_if #(.n(n), .w(w)) vals ();

    function automatic logic [w-1:0] absdiff(input logic [w-1:0] a, input logic [w-1:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction : absdiff

    logic [n-1:0] marked;
    assign marked = {busbar_channel_position_high_i, busbar_channel_position_low_i};

    assign vals.main_values = main_cell_values_i;
    assign vals.aux_values = aux_cell_values_i;
    assign vals.marked = marked;

    busbar_compare_unit #(.n(n), .w(w)) compare_unit (
        .vals(vals),
        .tolerance_i(compare_tolerance_i)
    );

    // open wire sinks
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busbar_positive_input_sink_o <= 1'b0;
            busbar_negative_input_sink_o <= 1'b0;
        end else begin
            busbar_positive_input_sink_o <= open_wire_sink_select_i == busbar_pkg::sink_all_on;
            busbar_negative_input_sink_o <= open_wire_sink_select_i == busbar_pkg::sink_all_on;
        end
    end

    // results pass unchanged; the bus bar channel shares the cell filter path upstream
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cell_result_pair_o <= '0;
        end else begin
            cell_result_pair_o <= main_cell_values_i;
        end
    end

    // common mode correction target; value stays at the shared cell, so sums are inherent
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            correction_channel_o <= busbar_pkg::locator_reset;
            correction_valid_o <= 1'b0;
        end else begin
            correction_channel_o <= shared_channel_locator_i;
            correction_valid_o <= shared_locator_valid_i;
        end
    end

    // protector masking
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            over_voltage_o <= '0;
            under_voltage_o <= '0;
        end else begin
            over_voltage_o <= protector_enable_i ? over_voltage_raw_i & ~marked : '0;
            under_voltage_o <= protector_enable_i ? under_voltage_raw_i & ~marked : '0;
        end
    end

    // balance switches: marked channel ignores voltage stop so the path above it stays intact
    logic [n-1:0] stop_now;
    assign stop_now = balance_timer_expired_i | (balance_voltage_reached_i & ~marked);
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            balance_switch_o <= '0;
        end else begin
            balance_switch_o <= balance_enable_i & ~stop_now;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            balancing_complete_flag_o <= 1'b0;
        end else begin
            // flag waits for every enabled switch, including bus bar timers
            balancing_complete_flag_o <= (|balance_enable_i) && ((balance_enable_i & ~stop_now) == '0);
        end
    end

    // compare scan over channels plus dedicated pair
    busbar_pkg::check_state_t state_r;
    logic [$clog2(n)-1:0] index_r;
    assign vals.index = index_r;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= busbar_pkg::check_idle;
            index_r <= '0;
        end else begin
            case (state_r)
                busbar_pkg::check_idle: begin
                    index_r <= '0;
                    if (compare_go_i) begin
                        state_r <= busbar_pkg::check_scan;
                    end
                end
                busbar_pkg::check_scan: begin
                    if (32'(index_r) == n - 1) begin
                        state_r <= busbar_pkg::check_done;
                    end else begin
                        index_r <= index_r + 1'b1;
                    end
                end
                busbar_pkg::check_done: begin
                    state_r <= busbar_pkg::check_idle;
                end
                default: begin
                    state_r <= busbar_pkg::check_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            compare_fault_o <= '0;
            busbar_compare_fault_o <= 1'b0;
            compare_done_o <= 1'b0;
        end else begin
            compare_done_o <= state_r == busbar_pkg::check_done;
            if (state_r == busbar_pkg::check_idle && compare_go_i) begin
                compare_fault_o <= '0;
                busbar_compare_fault_o <= 1'b0;
            end else if (state_r == busbar_pkg::check_scan) begin
                compare_fault_o[index_r] <= vals.mismatch;
            end else if (state_r == busbar_pkg::check_done) begin
                busbar_compare_fault_o <= absdiff(main_busbar_value_i, aux_busbar_value_i)
                    > compare_tolerance_i;
            end
        end
    end

    a_sink_both_on: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        busbar_positive_input_sink_o |-> $past(open_wire_sink_select_i) == 2'h3)
        else $error("sink on without all ones select");
    a_sink_pair_match: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        busbar_positive_input_sink_o == busbar_negative_input_sink_o)
        else $error("sinks differ");
    a_ov_masked: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (over_voltage_o & $past(marked)) == '0)
        else $error("over voltage on marked channel");
    a_uv_masked: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (under_voltage_o & $past(marked)) == '0)
        else $error("under voltage on marked channel");
    a_timer_stops: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ((balance_switch_o & $past(balance_timer_expired_i)) == '0))
        else $error("switch on after timer expiry");
    a_volt_stops: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ((balance_switch_o & $past(balance_voltage_reached_i) & ~$past(marked)) == '0))
        else $error("switch on after voltage reached");
    a_busbar_holds: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (marked[1] && balance_enable_i[1] && !balance_timer_expired_i[1]) |=> balance_switch_o[1])
        else $error("bus bar switch dropped early");
    // outputs still hold reset values at the first edge after release, so skip that edge
    a_result_pass: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> cell_result_pair_o == $past(main_cell_values_i))
        else $error("result not reported");
    a_scan_length: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (state_r == busbar_pkg::check_idle && compare_go_i) |-> ##18 compare_done_o)
        else $error("compare done late");
    a_locator_used: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> correction_channel_o == $past(shared_channel_locator_i))
        else $error("locator not applied");
    a_sink_turns_on: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ($past(rst_b_i) && $past(open_wire_sink_select_i) == 2'h3) |-> busbar_negative_input_sink_o)
        else $error("sink off with all ones select");
    a_fault_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (state_r == busbar_pkg::check_idle && compare_go_i) |=> (compare_fault_o == '0 && !busbar_compare_fault_o))
        else $error("faults not cleared on start");
    a_done_pulse: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        compare_done_o |=> !compare_done_o)
        else $error("done held too long");

    c_scan: cover property (@(posedge clock_i) disable iff (!rst_b_i) compare_done_o);
    c_busbar_fault: cover property (@(posedge clock_i) disable iff (!rst_b_i) busbar_compare_fault_o);
    c_complete: cover property (@(posedge clock_i) disable iff (!rst_b_i) balancing_complete_flag_o);
    c_sinks: cover property (@(posedge clock_i) disable iff (!rst_b_i) busbar_positive_input_sink_o);
endmodule : busbar_channel_handling
`default_nettype wire

// File: src/busbar_compare_unit.sv
// per-channel main versus auxiliary compare with bus bar summing
`timescale 1ns/10ps
`default_nettype none
module busbar_compare_unit #(
    parameter int unsigned n = 16,
    parameter int unsigned w = 16
) (
    // values
    busbar_value_if.unit vals,
    // tolerance
    input wire logic [w-1:0] tolerance_i
);
    function automatic logic [w:0] pick(input logic [n*w-1:0] v, input int unsigned i);
        pick = {1'b0, v[i*w +: w]};
    endfunction : pick

    function automatic logic [w:0] absdiff(input logic [w:0] a, input logic [w:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction : absdiff

    logic [w:0] main_sum;
    logic [w:0] aux_sum;
    int unsigned idx;
    always_comb begin
        idx = 32'(vals.index);
        main_sum = pick(vals.main_values, idx);
        aux_sum = pick(vals.aux_values, idx);
        // open upper balance pin makes the lone bus bar value meaningless on the aux path
        if (vals.marked[idx] && idx + 1 < n) begin
            main_sum = main_sum + pick(vals.main_values, idx + 1);
            aux_sum = aux_sum + pick(vals.aux_values, idx + 1);
        end else if (idx > 0 && vals.marked[idx-1]) begin
            main_sum = main_sum + pick(vals.main_values, idx - 1);
            aux_sum = aux_sum + pick(vals.aux_values, idx - 1);
        end
        vals.mismatch = absdiff(main_sum, aux_sum) > {1'b0, tolerance_i};
    end
endmodule : busbar_compare_unit
`default_nettype wire

// File: src/busbar_pkg.sv
// constants and types shared by the bus bar channel handling block
// What this block does
// - both dedicated bus bar input sinks turn on only when the sink select code is all ones.
// - a check compares the dedicated pair's differential value from the main converter against the auxiliary one.
// - when the dedicated pair shares a cell channel, the channel check uses the cell plus bus bar value.
// - a channel bus bar is measured and filtered like any cell and reported in that channel's result pair.
// - marked channels skip the balance voltage check and over and under voltage detection.
// - a marked channel below 15: main versus auxiliary check compares sums of bus bar and adjacent cell; marked channel 15 compares alone unless 14 is marked.
// - the switch of the cell above a bus bar stops on timer expiry or voltage reached, whichever first.
// - the bus bar channel switch stays on until its timer expires, so the complete flag may come late.
// - the host writes the shared channel locator and the device uses it for common mode correction.
package busbar_pkg;
    localparam int unsigned num_channels = 16;
    localparam int unsigned value_width = 16;
    localparam logic [1:0] sink_all_on = 2'h3;
    localparam logic [value_width-1:0] compare_tolerance_reset = 16'h0040;
    localparam logic [3:0] locator_reset = 4'h0;
    localparam int unsigned position_half = 8;

    typedef enum logic [1:0] {
        check_idle = 2'b00,
        check_scan = 2'b01,
        check_done = 2'b10
    } check_state_t;
endpackage : busbar_pkg

// File: src/busbar_value_if.sv
// interface carrying converter values and position marks to the compare unit
`timescale 1ns/10ps
`default_nettype none
interface busbar_value_if #(parameter int unsigned n = 16, parameter int unsigned w = 16);
    logic [n*w-1:0] main_values;
    logic [n*w-1:0] aux_values;
    logic [n-1:0] marked;
    logic [$clog2(n)-1:0] index;
    logic mismatch;
    modport ctrl (output main_values, output aux_values, output marked, output index, input mismatch);
    modport unit (input main_values, input aux_values, input marked, input index, output mismatch);
endinterface : busbar_value_if
`default_nettype wire

// File: test/busbar_channel_handling_tb.sv
// self-checking bench for the bus bar channel handling block
`timescale 1ns/10ps
`default_nettype none
module busbar_channel_handling_tb;
    typedef struct {logic [1:0] snk; logic [15:0] ov; logic [15:0] uv; logic [15:0] sw; logic cmp;
        logic [255:0] cel; logic cv; logic [3:0] cc;} lvl_t;
    typedef struct {logic [15:0] f; logic bf;} scn_t;
    logic clock_i = 0;
    logic rst_b_i = 0;
    logic [1:0] sel = 0;
    logic [3:0] pick = 0, loc = 0, cc;
    logic loc_v = 0, go = 0, pen = 0, snp, snn, cmp, bf, dn, cv;
    logic [15:0] tol = 16'h0040, mb = 0, ab = 0, ovr = 0, uvr = 0, breq = 0, treq = 0, rch = 0;
    logic [15:0] mk, ben, tmr, ov, uv, sw, cf;
    logic [255:0] mv = 0, av = 0, cel;
    int bad_count = 0, n_tests = 0, cyc = 0;
    lvl_t lq[$];
    scn_t sq[$];
    always #5 clock_i = ~clock_i;
    host_config_model host_u (.pick_i(pick), .bal_req_i(breq), .tmr_req_i(treq), .marked_o(mk), .bal_en_o(ben),
        .tmr_o(tmr));
    busbar_channel_handling dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .open_wire_sink_select_i(sel),
        .busbar_channel_position_low_i(mk[7:0]), .busbar_channel_position_high_i(mk[15:8]),
        .shared_channel_locator_i(loc), .shared_locator_valid_i(loc_v), .compare_tolerance_i(tol),
        .compare_go_i(go), .main_cell_values_i(mv), .aux_cell_values_i(av), .main_busbar_value_i(mb),
        .aux_busbar_value_i(ab), .over_voltage_raw_i(ovr), .under_voltage_raw_i(uvr),
        .protector_enable_i(pen), .balance_enable_i(ben), .balance_timer_expired_i(tmr),
        .balance_voltage_reached_i(rch), .busbar_positive_input_sink_o(snp), .busbar_negative_input_sink_o(snn),
        .cell_result_pair_o(cel), .over_voltage_o(ov), .under_voltage_o(uv), .balance_switch_o(sw),
        .balancing_complete_flag_o(cmp), .compare_fault_o(cf), .busbar_compare_fault_o(bf),
        .compare_done_o(dn), .correction_channel_o(cc), .correction_valid_o(cv));
    task automatic check(string nm, logic [255:0] seen, logic [255:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    // hang guard: the full sequence needs well under 1000 cycles
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict();
        end
    end
    // settled outputs are read just after the edge that updates them
    always @(posedge clock_i) begin
        lvl_t e;
        scn_t s;
        #1;
        if (lq.size() > 0) begin
            e = lq.pop_front();
            check("sink_pos", snp, e.snk[1]);
            check("sink_neg", snn, e.snk[0]);
            check("over_v", ov, e.ov);
            check("under_v", uv, e.uv);
            check("switch", sw, e.sw);
            check("complete", cmp, e.cmp);
            check("cells", cel, e.cel);
            check("corr_valid", cv, e.cv);
            if (e.cv) check("corr_chan", cc, e.cc);
        end
        if (dn === 1'b1 && sq.size() == 0) check("spurious_done", 1'b1, 1'b0);
        else if (dn === 1'b1) begin
            s = sq.pop_front();
            check("faults", cf, s.f);
            check("bb_fault", bf, s.bf);
        end
    end
    task automatic lvl_step(input logic [1:0] c);
        lvl_t e;
        @(negedge clock_i);
        sel = c;
        {pick, loc, loc_v, pen} = $urandom;
        {ovr, uvr} = $urandom;
        {breq, treq} = $urandom;
        rch = $urandom;
        for (int i = 0; i < 16; i++) mv[i*16+:16] = $urandom;
        // two edges let the registered complete flag catch up
        repeat (2) @(negedge clock_i);
        e.snk = {2{sel == 2'h3}};
        e.ov = ovr & ~mk & {16{pen}};
        e.uv = uvr & ~mk & {16{pen}};
        e.sw = ben & ~(tmr | (rch & ~mk));
        e.cmp = (ben != 16'h0000) && ((ben & e.sw) == 16'h0000);
        e.cel = mv;
        e.cv = loc_v;
        e.cc = loc;
        lq.push_back(e);
    endtask : lvl_step
    task automatic scan(input logic [3:0] p);
        scn_t s;
        logic [17:0] ms, as;
        logic [15:0] lo;
        int k;
        @(negedge clock_i);
        pick = p;
        loc_v = 0;
        mb = 16'h0100 + $urandom % 16'h0100;
        // spread wider than the tolerance so the dedicated pair fault can trip
        ab = mb + $urandom % 16'h0100 - 16'h0080;
        for (int i = 0; i < 16; i++) begin
            mv[i*16+:16] = 16'h0100 + $urandom % 16'h3E00;
            av[i*16+:16] = mv[i*16+:16] + $urandom % 16'h00C0 - 16'h0060;
        end
        #1;
        lo = mk << 1;
        for (int i = 0; i < 16; i++) begin
            ms = mv[i*16+:16];
            as = av[i*16+:16];
            if (i < 15 && mk[i]) begin
                ms += mv[i*16+16+:16];
                as += av[i*16+16+:16];
            end
            if (lo[i]) begin
                ms += mv[i*16-16+:16];
                as += av[i*16-16+:16];
            end
            s.f[i] = ((ms > as) ? ms - as : as - ms) > tol;
        end
        s.bf = ((mb > ab) ? mb - ab : ab - mb) > tol;
        sq.push_back(s);
        go = 1;
        @(negedge clock_i);
        go = 0;
        k = 0;
        while (dn !== 1'b1 && k < 40) begin
            @(posedge clock_i);
            #1;
            k++;
        end
        check("done_gap", k, 17);
    endtask : scan
    initial begin
        void'($urandom(32'h771CF9B6));
        repeat (16) @(posedge clock_i);
        @(negedge clock_i);
        rst_b_i = 1;
        for (int k = 0; k < 40; k++) lvl_step(k[1:0]);
        $display("test levels done");
        for (int k = 0; k < 9; k++) scan(4'(k * 2 - 1));
        $display("test scans done");
        @(negedge clock_i);
        rst_b_i = 0;
        sel = 2'h3;
        @(negedge clock_i);
        check("rst_sink", snp, 1'b0);
        check("rst_faults", cf, 16'h0000);
        rst_b_i = 1;
        $display("test reset done");
        repeat (3) @(negedge clock_i);
        print_verdict();
    end
endmodule : busbar_channel_handling_tb
`default_nettype wire

// File: test/host_config_model.sv
// host model: legal bus bar placement and paired balancing requests
`timescale 1ns/10ps
`default_nettype none
module host_config_model (
    // placement and balancing requests
    input wire logic [3:0] pick_i,
    input wire logic [15:0] bal_req_i,
    input wire logic [15:0] tmr_req_i,
    // configuration seen by the device
    output logic [15:0] marked_o,
    output logic [15:0] bal_en_o,
    output logic [15:0] tmr_o
);
    logic [3:0] a;
    logic [3:0] b;
    always_comb begin
        a = (pick_i == 4'h0) ? 4'h1 : pick_i;
        b = (a > 4'hD) ? a - 4'h2 : a + 4'h2;
        marked_o = (16'h0001 << a) | (16'h0001 << b);
        // the bus bar switch must follow the cell above it, same timer
        bal_en_o = bal_req_i | ((bal_req_i >> 1) & marked_o);
        tmr_o = tmr_req_i | ((tmr_req_i >> 1) & marked_o);
    end
endmodule : host_config_model
`default_nettype wire
